//--- hdl/rts_pkg.sv
// constants and types shared by the reset time-out sequencer
`default_nettype none
package rts_pkg;
  // apb register byte offsets
  localparam logic [7:0] RTS_OFF_CAUSE = 8'h00; // reset cause bits
  localparam logic [7:0] RTS_OFF_STAT = 8'h04; // sequencer state, live inputs
  localparam logic [7:0] RTS_OFF_IRQ = 8'h08; // sticky event bits
  localparam logic [7:0] RTS_OFF_MASK = 8'h0C; // event mask
  // field positions
  localparam int RTS_BIT_BROWNOUT = 0;
  localparam int RTS_BIT_POWERON = 1;
  localparam int RTS_EV_RELEASE = 0;
  localparam int RTS_EV_BROWNOUT = 1;
  // reset values
  localparam logic [1:0] RTS_CAUSE_RST = 2'h0;
  localparam logic [1:0] RTS_MASK_RST = 2'h0;
  // timing
  localparam int RTS_CLK_HZ = 10000000;
  localparam int RTS_PWRUP_MS = 72; // power_up_delay_time
  localparam int RTS_PWRUP_CYC = RTS_PWRUP_MS * (RTS_CLK_HZ / 1000);
  localparam int RTS_RC_DIV = 10; // pclk cycles per internal rc tick
  localparam int RTS_PWRUP_TICKS = RTS_PWRUP_CYC / RTS_RC_DIV;
  localparam int RTS_BOR_US = 100; // brownout_min_duration
  localparam int RTS_BOR_CYC = (RTS_BOR_US * (RTS_CLK_HZ / 1000000)) + 1;
  localparam int RTS_OST_CYC = 1024; // oscillator_startup_counter length
  // oscillator modes
  typedef enum logic [1:0] {
    RTS_OSC_LP = 2'b00, RTS_OSC_XT = 2'b01, RTS_OSC_HS = 2'b10, RTS_OSC_RC = 2'b11
  } rts_osc_t;
  // sequencer states
  typedef enum logic [2:0] {
    RTS_ST_POR = 3'b000, RTS_ST_PWRUP = 3'b001, RTS_ST_OST = 3'b010,
    RTS_ST_RUN = 3'b011, RTS_ST_BOR = 3'b100
  } rts_state_t;
endpackage : rts_pkg
`default_nettype wire

//--- hdl/rts_sequencer.sv
// reset time-out sequencer with apb status registers
// What this block does
// - supply rise makes reset pulse, starts sequence
// - 72 ms delay only after power-on/brown-out
// - core held in reset during delay
// - active-low fuse enables power-up delay
// - then 1024 oscillator cycles counted
// - oscillator count only crystal modes, not rc
// - brown-out fuse gates brown-out reset
// - dip longer than minimum duration resets
// - stay reset until supply back, then delay
// - new dip during delay restarts brown-out
// - brown-out enabled forces power-up delay
// - delays in order, release after last
// - timers run under master clear low
// - bit 0 cleared by brown-out reset
// - bit 0 meaningless with brown-out off
// - bit 1 cleared by power-on, by presetn or by an apb write of 0
`default_nettype none
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int PWRUP_TICKS = rts_pkg::RTS_PWRUP_TICKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply monitors and pins, asynchronous
  input wire logic supply_rise_det,
  input wire logic brownout_below,
  input wire logic master_clear_n,
  input wire logic oscillator_input,
  input wire logic wake_from_sleep,
  // fuses and mode, static
  input wire logic power_delay_enable_n,
  input wire logic brownout_enable_fuse,
  input wire logic [1:0] osc_mode,
  // outputs
  output logic core_reset_hold,
  output logic irq
);
  import rts_pkg::*;

  // all state in one struct
  typedef struct packed {
    logic [1:0] s_rise; // supply rise sync
    logic [1:0] s_bor; // brown-out sync
    logic [1:0] s_master_clear_n; // master clear sync
    logic [1:0] s_osc; // oscillator sync
    logic [1:0] s_wake; // wake sync
    logic rise_q; // last synced rise level
    logic osc_q; // last synced oscillator level
    logic wake_q; // last synced wake level
    rts_state_t st; // sequencer state
    logic [3:0] rc_div; // rc tick divider
    logic [19:0] pw_cnt; // power-up ticks
    logic [10:0] ost_cnt; // oscillator edges
    logic [10:0] bor_cnt; // dip length
    logic [1:0] cause; // reset cause bits
    logic [1:0] evt; // sticky events
    logic [1:0] mask; // event mask
    logic [31:0] prdata;
    logic pready;
    logic hold;
    logic irq;
  } rts_reg_t;

  rts_reg_t cur;
  rts_reg_t nxt;

  logic rise_pulse; // power-on reset pulse
  logic osc_rise; // oscillator rising edge
  logic wake_pulse; // sleep wake event
  logic bor_active; // qualified brown-out
  logic ost_needed; // crystal type mode
  logic pw_needed; // power-up delay applies
  logic apb_acc; // apb access phase
  logic rc_tick; // internal rc tick

  // derived terms, read only from second sync stages
  always_comb
  begin
    rise_pulse = cur.s_rise[1] && !cur.rise_q;
    osc_rise = cur.s_osc[1] && !cur.osc_q;
    wake_pulse = cur.s_wake[1] && !cur.wake_q;
    ost_needed = (rts_osc_t'(osc_mode) != RTS_OSC_RC);
    pw_needed = !power_delay_enable_n || brownout_enable_fuse;
    bor_active = brownout_enable_fuse && (cur.bor_cnt == 11'(RTS_BOR_CYC));
    apb_acc = psel && penable && !cur.pready;
    rc_tick = (cur.rc_div == 4'(RTS_RC_DIV - 1));
  end

  // next-state logic
  always_comb
  begin
    nxt = cur;
    nxt.s_rise = {cur.s_rise[0], supply_rise_det};
    nxt.s_bor = {cur.s_bor[0], brownout_below};
    nxt.s_master_clear_n = {cur.s_master_clear_n[0], master_clear_n};
    nxt.s_osc = {cur.s_osc[0], oscillator_input};
    nxt.s_wake = {cur.s_wake[0], wake_from_sleep};
    nxt.rise_q = cur.s_rise[1];
    nxt.osc_q = cur.s_osc[1];
    nxt.wake_q = cur.s_wake[1];
    // free-running rc tick divider
    nxt.rc_div = rc_tick ? 4'h0 : cur.rc_div + 4'h1;
    // brown-out dip length, saturating at the minimum duration
    if (!cur.s_bor[1])
    begin
      nxt.bor_cnt = 11'h000;
    end
    else if (cur.bor_cnt != 11'(RTS_BOR_CYC))
    begin
      nxt.bor_cnt = cur.bor_cnt + 11'h001;
    end
    // sequencer; timers ignore master clear, it only gates the output
    case (cur.st)
      RTS_ST_POR:
      begin
        nxt.pw_cnt = 20'h00000;
        nxt.ost_cnt = 11'h000;
        nxt.st = pw_needed ? RTS_ST_PWRUP : (ost_needed ? RTS_ST_OST : RTS_ST_RUN);
      end
      RTS_ST_PWRUP:
      begin
        if (rc_tick)
        begin
          nxt.pw_cnt = cur.pw_cnt + 20'h00001;
        end
        if (cur.pw_cnt == 20'(PWRUP_TICKS))
        begin
          nxt.st = ost_needed ? RTS_ST_OST : RTS_ST_RUN;
        end
      end
      RTS_ST_OST:
      begin
        if (osc_rise)
        begin
          nxt.ost_cnt = cur.ost_cnt + 11'h001;
        end
        if (cur.ost_cnt == 11'(RTS_OST_CYC))
        begin
          nxt.st = RTS_ST_RUN;
        end
      end
      RTS_ST_RUN:
      begin
        // wake from sleep reruns only the oscillator count
        if (wake_pulse && ost_needed)
        begin
          nxt.ost_cnt = 11'h000;
          nxt.st = RTS_ST_OST;
        end
      end
      RTS_ST_BOR:
      begin
        // held until supply back, then full power-up delay
        nxt.pw_cnt = 20'h00000;
        nxt.ost_cnt = 11'h000;
        if (!cur.s_bor[1])
        begin
          nxt.st = RTS_ST_PWRUP;
        end
      end
      default:
      begin
        nxt.st = RTS_ST_POR;
      end
    endcase
    // brown-out wins from any state, also aborts a running delay
    if (bor_active)
    begin
      nxt.st = RTS_ST_BOR;
      nxt.cause[RTS_BIT_BROWNOUT] = 1'b0;
    end
    // power-on pulse restarts everything
    if (rise_pulse)
    begin
      nxt.st = RTS_ST_POR;
      nxt.cause[RTS_BIT_POWERON] = 1'b0;
    end
    // apb slave, one wait state: pready in second cycle after setup
    nxt.pready = apb_acc;
    nxt.prdata = 32'h0000_0000;
    if (apb_acc && !pwrite)
    begin
      case (paddr)
        RTS_OFF_CAUSE: nxt.prdata = {30'h0, cur.cause};
        RTS_OFF_STAT: nxt.prdata = {24'h0, cur.s_master_clear_n[1], cur.s_bor[1], 1'b0, cur.hold,
                                    1'b0, cur.st};
        RTS_OFF_IRQ: nxt.prdata = {30'h0, cur.evt};
        RTS_OFF_MASK: nxt.prdata = {30'h0, cur.mask};
        default: nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_acc && pwrite)
    begin
      case (paddr)
        RTS_OFF_CAUSE: nxt.cause = pwdata[1:0] & {!rise_pulse, !bor_active};
        RTS_OFF_IRQ: nxt.evt = cur.evt & ~pwdata[1:0];
        RTS_OFF_MASK: nxt.mask = pwdata[1:0];
        default: nxt.mask = cur.mask;
      endcase
    end
    // hold: timers running or master clear low
    // worked out before the events so the release edge can be seen here
    nxt.hold = (nxt.st != RTS_ST_RUN) || !cur.s_master_clear_n[1];
    // events set after clear so a coincident event wins
    if (cur.hold && !nxt.hold)
    begin
      nxt.evt[RTS_EV_RELEASE] = 1'b1;
    end
    if (bor_active && cur.st != RTS_ST_BOR)
    begin
      nxt.evt[RTS_EV_BROWNOUT] = 1'b1;
    end
    nxt.irq = |(nxt.evt & nxt.mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur <= '{st: RTS_ST_POR, hold: 1'b1, cause: RTS_CAUSE_RST, mask: RTS_MASK_RST,
               default: '0};
    end
    else
    begin
      cur <= nxt;
    end
  end

  // outputs straight from flops
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = 1'b0;
  assign core_reset_hold = cur.hold;
  assign irq = cur.irq;

  // assertions
  property p_run_needs_release;
    @(posedge pclk) disable iff (!presetn)
    (cur.st != RTS_ST_RUN) |-> core_reset_hold;
  endproperty
  a_run_needs_release: assert property (p_run_needs_release) else $error("hold dropped early");

  property p_bor_enters;
    @(posedge pclk) disable iff (!presetn)
    (bor_active && !rise_pulse) |=> (cur.st == RTS_ST_BOR && !cur.cause[RTS_BIT_BROWNOUT]);
  endproperty
  a_bor_enters: assert property (p_bor_enters) else $error("brown-out not taken");

  property p_bor_fuse;
    @(posedge pclk) disable iff (!presetn)
    (!brownout_enable_fuse && cur.st != RTS_ST_BOR) |=> (cur.st != RTS_ST_BOR);
  endproperty
  a_bor_fuse: assert property (p_bor_fuse) else $error("brown-out while fused off");

  property p_por_clears;
    @(posedge pclk) disable iff (!presetn)
    rise_pulse |=> (!cur.cause[RTS_BIT_POWERON] && cur.st == RTS_ST_POR);
  endproperty
  a_por_clears: assert property (p_por_clears) else $error("power-on not taken");

  property p_rc_skips_ost;
    @(posedge pclk) disable iff (!presetn)
    (rts_osc_t'(osc_mode) == RTS_OSC_RC && cur.st != RTS_ST_OST) |=> (cur.st != RTS_ST_OST);
  endproperty
  a_rc_skips_ost: assert property (p_rc_skips_ost) else $error("rc mode counted osc");

  property p_ost_done;
    @(posedge pclk) disable iff (!presetn)
    (cur.st == RTS_ST_OST && cur.ost_cnt != 11'(RTS_OST_CYC)) |=> (cur.st != RTS_ST_RUN);
  endproperty
  a_ost_done: assert property (p_ost_done) else $error("osc count cut short");

  property p_pwrup_full;
    @(posedge pclk) disable iff (!presetn)
    (cur.st == RTS_ST_PWRUP && cur.pw_cnt != 20'(PWRUP_TICKS) && !bor_active && !rise_pulse)
      |=> (cur.st == RTS_ST_PWRUP);
  endproperty
  a_pwrup_full: assert property (p_pwrup_full) else $error("power-up delay cut short");

  property p_master_clear_n_release;
    @(posedge pclk) disable iff (!presetn)
    (cur.st == RTS_ST_RUN && cur.s_master_clear_n[1] && !rise_pulse && !bor_active && !wake_pulse)
      |=> !core_reset_hold;
  endproperty
  a_master_clear_n_release: assert property (p_master_clear_n_release) else $error("no immediate release");

  // sequences for the brown-out recovery steps
  sequence s_in_bor;
    cur.st == RTS_ST_BOR;
  endsequence
  sequence s_supply_back;
    !cur.s_bor[1] && !bor_active && !rise_pulse;
  endsequence

  // supply back above threshold starts a fresh power-up delay
  property p_bor_recover;
    @(posedge pclk) disable iff (!presetn)
    s_in_bor ##0 s_supply_back |=> (cur.st == RTS_ST_PWRUP);
  endproperty
  a_bor_recover: assert property (p_bor_recover) else $error("no delay after dip");

  // core stays held while in brown-out
  property p_bor_hold;
    @(posedge pclk) disable iff (!presetn)
    s_in_bor |=> core_reset_hold;
  endproperty
  a_bor_hold: assert property (p_bor_hold) else $error("hold lost in brown-out");

  // short dips must not enter brown-out
  property p_short_dip;
    @(posedge pclk) disable iff (!presetn)
    (!bor_active && cur.st != RTS_ST_BOR) |=> (cur.st != RTS_ST_BOR);
  endproperty
  a_short_dip: assert property (p_short_dip) else $error("short dip reset");

  // fuse high and brown-out off skips the delay
  property p_pwr_skip;
    @(posedge pclk) disable iff (!presetn)
    (cur.st == RTS_ST_POR && power_delay_enable_n && !brownout_enable_fuse && !rise_pulse
      && !bor_active) |=> (cur.st != RTS_ST_PWRUP);
  endproperty
  a_pwr_skip: assert property (p_pwr_skip) else $error("delay not skipped");

  // brown-out enabled forces the delay whatever the fuse says
  property p_bor_forces_delay;
    @(posedge pclk) disable iff (!presetn)
    (cur.st == RTS_ST_POR && brownout_enable_fuse && !rise_pulse && !bor_active)
      |=> (cur.st == RTS_ST_PWRUP);
  endproperty
  a_bor_forces_delay: assert property (p_bor_forces_delay) else $error("delay missing");

  // wake reruns only the oscillator count, from zero
  property p_wake_ost;
    @(posedge pclk) disable iff (!presetn)
    (cur.st == RTS_ST_RUN && wake_pulse && ost_needed && !bor_active && !rise_pulse)
      |=> (cur.st == RTS_ST_OST && cur.ost_cnt == 11'h000);
  endproperty
  a_wake_ost: assert property (p_wake_ost) else $error("wake did not recount");

  // master clear low always holds the core
  property p_master_clear_n_holds;
    @(posedge pclk) disable iff (!presetn)
    !cur.s_master_clear_n[1] |=> core_reset_hold;
  endproperty
  a_master_clear_n_holds: assert property (p_master_clear_n_holds) else $error("master clear ignored");

  // every release leaves its sticky event behind
  property p_release_event;
    @(posedge pclk) disable iff (!presetn)
    $fell(core_reset_hold) |-> cur.evt[RTS_EV_RELEASE];
  endproperty
  a_release_event: assert property (p_release_event) else $error("release not flagged");

  // pready is a one-cycle pulse, one wait state per access
  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");

  // read data only stands with pready
  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
endmodule : rts_sequencer
`default_nettype wire

//--- testbench/rts_supply_model.sv
// supply monitors and crystal standing at the sequencer's far side
`default_nettype none
module rts_supply_model (
  // bench controls
  input wire logic vdd_up,
  input wire logic vdd_low,
  // toward the sequencer
  output logic supply_rise_det,
  output var logic oscillator_input,
  output logic brownout_below
);
  timeunit 1ns;
  timeprecision 1ns;
  // free-running crystal, period 5 pclk so it stays under pclk/4
  initial
  begin
    oscillator_input = 1'b0;
    forever #250 oscillator_input = ~oscillator_input;
  end
  // rise detector follows the supply rail
  assign supply_rise_det = vdd_up;
  // comparator only meaningful while the rail is up
  assign brownout_below = vdd_up & vdd_low;
endmodule // rts_supply_model
`default_nettype wire

//--- testbench/tb_rts_sequencer.sv
// self-checking bench for the reset time-out sequencer
`default_nettype none
module tb_rts_sequencer
  import rts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = 150; // shortened, still longer than the minimum dip
  localparam int OSC_CYC = 5; // pclk cycles per crystal period
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, hold;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic vdd_up, vdd_low, master_clear_n_n, wake, fuse_n, bor_en, sup, bl, osc;
  logic [1:0] mode;
  int error_cnt = 0;
  int samples_checked = 0;
  int n, e;
  rts_supply_model rts_supply_model_inst (.vdd_up(vdd_up), .vdd_low(vdd_low),
    .supply_rise_det(sup), .oscillator_input(osc), .brownout_below(bl));
  rts_sequencer #(.PWRUP_TICKS(PW)) rts_sequencer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_rise_det(sup),
    .brownout_below(bl), .master_clear_n(master_clear_n_n), .oscillator_input(osc),
    .wake_from_sleep(wake), .power_delay_enable_n(fuse_n), .brownout_enable_fuse(bor_en),
    .osc_mode(mode), .core_reset_hold(hold), .irq(irq));
  // shortest release delay: tick and crystal phase can each save one period
  function automatic int exp_cyc(logic fn, logic be, logic [1:0] m);
    exp_cyc = ((!fn || be) ? (PW - 1) * RTS_RC_DIV : 0)
      + ((m != RTS_OSC_RC) ? (RTS_OST_CYC - 1) * OSC_CYC : 0);
  endfunction
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // count cycles until the core is let go
  task automatic wait_release();
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (hold !== 1'b0 && n < 8000);
  endtask
  task automatic power_on();
    @(posedge pclk);
    vdd_up <= 1'b0;
    repeat (5) @(posedge pclk);
    vdd_up <= 1'b1;
    // sync, edge detect and state step before hold shows the pulse
    repeat (4) @(posedge pclk);
    chk({31'h0, hold}, 32'h1);
    wait_release();
    n = n + 4;
  endtask
  task automatic dip(input int len);
    @(posedge pclk);
    vdd_low <= 1'b1;
    repeat (len) @(posedge pclk);
    vdd_low <= 1'b0;
  endtask
  // 100 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // watchdog, about twice the longest expected run
  initial
  begin
    #(100 * 80000);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, vdd_up, vdd_low, wake} = '0;
    {master_clear_n_n, fuse_n, bor_en, mode} = {1'b1, 1'b0, 1'b0, RTS_OSC_XT};
    void'($urandom(60));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RTS_OFF_CAUSE, 32'h0);
    chk(rd, 32'(RTS_CAUSE_RST));
    apb(1'b0, RTS_OFF_MASK, 32'h0);
    chk(rd, 32'(RTS_MASK_RST));
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    // every oscillator mode, fuses at random
    for (int m = 0; m < 4; m++)
    begin
      fuse_n <= 1'($urandom);
      bor_en <= 1'($urandom);
      mode <= 2'(m);
      apb(1'b1, RTS_OFF_CAUSE, 32'h3);
      power_on();
      e = exp_cyc(fuse_n, bor_en, mode);
      chk(32'(n >= e && n <= e + 60), 32'h1);
      apb(1'b0, RTS_OFF_CAUSE, 32'h0);
      chk(32'(rd[1]), 32'h0);
    end
    // brown-out: short dip ignored, long dip resets, re-dip restarts
    {bor_en, fuse_n, mode} <= {1'b1, 1'b1, RTS_OSC_XT};
    apb(1'b1, RTS_OFF_CAUSE, 32'h3);
    apb(1'b1, RTS_OFF_MASK, 32'h2);
    dip(100 + $urandom_range(800));
    apb(1'b0, RTS_OFF_CAUSE, 32'h0);
    chk({31'h0, hold}, 32'h0);
    chk(rd, 32'h3);
    dip(1100);
    chk({30'h0, hold, irq}, 32'h3);
    // second dip lands inside the post brown-out power-up delay
    repeat (100) @(posedge pclk);
    dip(1100);
    chk({31'h0, hold}, 32'h1);
    wait_release();
    e = exp_cyc(1'b1, 1'b1, RTS_OSC_XT);
    chk(32'(n >= e && n <= e + 60), 32'h1);
    apb(1'b0, RTS_OFF_CAUSE, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, RTS_OFF_IRQ, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, RTS_OFF_IRQ, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, RTS_OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, RTS_OFF_IRQ, 32'h1);
    apb(1'b0, RTS_OFF_IRQ, 32'h0);
    chk({irq, rd[30:0]}, 32'h0);
    // brown-out fuse off: a long dip does nothing
    bor_en <= 1'b0;
    dip(1100);
    chk({31'h0, hold}, 32'h0);
    // master clear held over the whole power-up delay
    {mode, master_clear_n_n, fuse_n} <= {RTS_OSC_RC, 1'b0, 1'b0};
    vdd_up <= 1'b0;
    repeat (5) @(posedge pclk);
    vdd_up <= 1'b1;
    repeat (1700) @(posedge pclk);
    chk({31'h0, hold}, 32'h1);
    master_clear_n_n <= 1'b1;
    wait_release();
    chk(32'(n <= 6), 32'h1);
    apb(1'b0, RTS_OFF_STAT, 32'h0);
    chk(32'(rd[2:0]), 32'(RTS_ST_RUN));
    // wake from sleep reruns only the crystal count
    mode <= RTS_OSC_XT;
    wake <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, hold}, 32'h1);
    wait_release();
    e = exp_cyc(1'b1, 1'b0, RTS_OSC_XT);
    chk(32'(n + 4 >= e && n + 4 <= e + 60), 32'h1);
    wake <= 1'b0;
    finish_test();
  end
endmodule // tb_rts_sequencer
`default_nettype wire
